// file: rtl/ahd_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef AHD_MAP_SVH
`define AHD_MAP_SVH
`define AHD_AXES 4
`define AHD_CLK_MHZ 125
`define AHD_STEP_HI_NS 1000
`define AHD_STEP_HI_CYC ((`AHD_STEP_HI_NS * `AHD_CLK_MHZ + 999) / 1000)
`define AHD_RAMP_STEPS 8
`define AHD_CTRL_OFS 8'h00
`define AHD_CMD_OFS 8'h04
`define AHD_PARAM_OFS 8'h08
`define AHD_STAT_OFS 8'h0c
`define AHD_DFLAG_OFS 8'h10
`define AHD_VEL_OFS 8'h20
`define AHD_NEAR_OFS 8'h30
`define AHD_POS_OFS 8'h40
`define AHD_CTRL_MODE 1:0
`define AHD_CTRL_INDEP 2
`define AHD_CTRL_IRQEN 3
`define AHD_CTRL_HOLD 7:4
`define AHD_CTRL_NEAREN 11:8
`define AHD_CMD_OP 2:0
`define AHD_CMD_AXIS 5:4
`define AHD_CMD_HASPAR 8
`define AHD_CTRL_RST 12'h000
`define AHD_VEL_RST 24'h01e848
`define AHD_NEAR_RST 16'h0000
`define AHD_RESP_OK 2'b00
`define AHD_RESP_ERR 2'b10
`endif

// file: rtl/ahd_pkg.sv
// Types and shared helpers of the axis homing and done block
package ahd_pkg;
  typedef enum logic [2:0] {AHD_OP_NONE, AHD_OP_HOME_FWD, AHD_OP_HOME_REV, AHD_OP_KILL_FWD,
    AHD_OP_KILL_REV, AHD_OP_CLEAR} ahd_op_e;
  typedef enum logic [1:0] {AHD_MODE_SINGLE, AHD_MODE_EVERY, AHD_MODE_ACTIVE} ahd_mode_e;
  typedef logic [23:0] ahd_rate_t;
  typedef logic [31:0] ahd_word_t;

  function automatic ahd_word_t ahd_strb(ahd_word_t old, ahd_word_t nw, logic [3:0] strb);
    for (int b = 0; b < 4; b++) begin
      ahd_strb[b*8 +: 8] = strb[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction : ahd_strb

  function automatic logic ahd_multi(logic [1:0] m);
    ahd_multi = (m != 2'(AHD_MODE_SINGLE));
  endfunction : ahd_multi
endpackage : ahd_pkg

// file: rtl/ahd_stepgen.sv
// Step pulse generator with a stretching deceleration ramp
`timescale 1ns/1ps
`include "ahd_map.svh"
module ahd_stepgen
  import ahd_pkg::*;
(
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic run_in,
  input wire logic ramp_in,
  input wire logic kill_in,
  input wire ahd_rate_t period_in,
  output logic step_out,
  output logic step_evt_out,
  output logic done_out
);
  localparam ahd_rate_t HI = ahd_rate_t'(`AHD_STEP_HI_CYC);
  localparam ahd_rate_t MIN = ahd_rate_t'(2 * `AHD_STEP_HI_CYC);
  localparam logic [3:0] RAMP = 4'(`AHD_RAMP_STEPS);
  ahd_rate_t cnt;
  ahd_rate_t cur;
  logic ramping;
  logic [3:0] left;
  logic live;
  logic wrap;

  assign live = run_in && !kill_in;
  assign wrap = (cnt == cur - 24'h000001);
  assign step_evt_out = live && (cnt == 24'h000000);

  always_ff @(posedge clk_in) begin
    if (srst_in || !live) begin
      cnt <= 24'h000000;
      cur <= (period_in < MIN) ? MIN : period_in;
    end else begin
      cnt <= wrap ? 24'h000000 : cnt + 24'h000001;
      // Each ramp step lengthens the period by a quarter, saturating near the top
      if (wrap && ramping && cur[23:22] == 2'h0) begin
        cur <= cur + (cur >> 2);
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in || !live) begin
      ramping <= 1'b0;
      left <= 4'h0;
    end else if (ramp_in) begin
      ramping <= 1'b1;
      left <= RAMP;
    end else if (wrap && ramping) begin
      left <= left - 4'h1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      step_out <= 1'b0;
      done_out <= 1'b0;
    end else begin
      step_out <= live && (cnt < HI);
      done_out <= live && wrap && ramping && (left == 4'h1);
    end
  end
endmodule : ahd_stepgen

// file: rtl/ahd_axis.sv
// One axis: seek home, load or keep the position, ramp down or kill
`timescale 1ns/1ps
module ahd_axis
  import ahd_pkg::*;
(
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic start_in,
  input wire logic dir_in,
  input wire logic kill_mode_in,
  input wire ahd_word_t load_in,
  input wire ahd_rate_t period_in,
  input wire logic home_in,
  output logic step_out,
  output logic dir_out,
  output logic busy_out,
  output ahd_word_t pos_out
);
  typedef enum logic [1:0] {AX_IDLE, AX_SEEK, AX_DECEL} ahd_axst_e;
  ahd_axst_e state;
  logic kill_mode;
  ahd_word_t load_val;
  logic hit;
  logic evt;
  logic gen_done;

  assign hit = (state == AX_SEEK) && home_in;
  assign busy_out = (state != AX_IDLE);

  ahd_stepgen u_gen (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .run_in(busy_out),
    .ramp_in(hit && !kill_mode),
    .kill_in(hit && kill_mode),
    .period_in(period_in),
    .step_out(step_out),
    .step_evt_out(evt),
    .done_out(gen_done)
  );

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state <= AX_IDLE;
    end else begin
      unique case (state)
        AX_IDLE: if (start_in) state <= AX_SEEK;
        AX_SEEK: if (home_in) state <= kill_mode ? AX_IDLE : AX_DECEL;
        AX_DECEL: if (gen_done) state <= AX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      dir_out <= 1'b0;
      kill_mode <= 1'b0;
      load_val <= 32'h00000000;
    end else if (start_in && state == AX_IDLE) begin
      dir_out <= dir_in;
      kill_mode <= kill_mode_in;
      load_val <= load_in;
    end
  end

  // Kill leaves the count alone; a ramped home loads it at the switch
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      pos_out <= 32'h00000000;
    end else if (hit && !kill_mode) begin
      pos_out <= load_val;
    end else if (evt) begin
      pos_out <= dir_out ? pos_out - 32'h00000001 : pos_out + 32'h00000001;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  a_fwd_seek: assert property (start_in && !busy_out && !dir_in |=>
    state == AX_SEEK && !dir_out) else $error("forward home did not seek upward");
  a_rev_seek: assert property (start_in && !busy_out && dir_in |=>
    state == AX_SEEK && dir_out) else $error("reverse home did not seek downward");
  a_home_load: assert property (hit && !kill_mode |=>
    pos_out == $past(load_val) && state == AX_DECEL) else $error("home load missed");
  a_kill_stop: assert property (hit && kill_mode && !dir_out |=>
    state == AX_IDLE && !step_out && $stable(pos_out)) else $error("kill did not stop");
  a_rev_kill: assert property (hit && kill_mode && dir_out |=>
    state == AX_IDLE && !step_out && $stable(pos_out)) else $error("reverse kill failed");
  c_home_ramp: cover property (state == AX_DECEL && gen_done);
endmodule : ahd_axis

// file: rtl/ahd_top.sv
// Homing commands, done flags and host interrupt behind an AXI4-Lite slave
`timescale 1ns/1ps
`include "ahd_map.svh"
module ahd_top
  import ahd_pkg::*;
(
  input wire logic REF_CLK_IN,
  input wire logic SRST_IN,
  input wire logic [7:0] AXI_AWADDR_IN,
  input wire logic AXI_AWVALID_IN,
  output logic AXI_AWREADY_OUT,
  input wire logic [31:0] AXI_WDATA_IN,
  input wire logic [3:0] AXI_WSTRB_IN,
  input wire logic AXI_WVALID_IN,
  output logic AXI_WREADY_OUT,
  output logic [1:0] AXI_BRESP_OUT,
  output logic AXI_BVALID_OUT,
  input wire logic AXI_BREADY_IN,
  input wire logic [7:0] AXI_ARADDR_IN,
  input wire logic AXI_ARVALID_IN,
  output logic AXI_ARREADY_OUT,
  output logic [31:0] AXI_RDATA_OUT,
  output logic [1:0] AXI_RRESP_OUT,
  output logic AXI_RVALID_OUT,
  input wire logic AXI_RREADY_IN,
  input wire logic [3:0] HOME_IN,
  output logic [3:0] STEP_OUT,
  output logic [3:0] DIR_OUT,
  input wire logic [3:0] DONE_IRQ_CMD_IN,
  input wire logic [3:0] DEADBAND_DONE_CMD_IN,
  input wire logic [3:0] IN_DEADBAND_IN,
  input wire logic [3:0] MOVE_AXES_IN,
  input wire logic [3:0] MOVE_DONE_IN,
  input wire logic [3:0] DECEL_IN,
  input wire logic [63:0] REMAIN_IN,
  input wire logic START_MOVE_CLEAR_DONE_IN,
  output logic IRQ_OUT
);
  logic aw_ok;
  logic w_ok;
  logic [7:0] wr_addr;
  ahd_word_t wdata;
  logic [3:0] wstrb;
  logic wr_go;
  logic [11:0] ctrl;
  ahd_word_t param;
  ahd_rate_t vel [4];
  logic [15:0] near [4];
  ahd_word_t pos [4];
  logic [1:0] mode;
  logic [3:0] hold;
  logic [3:0] near_en;
  logic cmd_go;
  ahd_op_e op;
  logic [1:0] ax;
  logic is_home;
  logic home_ok;
  logic home_rej;
  logic flag_clear;
  logic clr_done;
  logic [3:0] start;
  logic [3:0] busy;
  ahd_word_t load;
  logic [3:0] de;
  logic [3:0] de_g;
  logic [3:0] ie;
  logic [3:0] next_flags;
  logic [3:0] axis_done;
  logic [3:0] pend_db;
  logic [3:0] near_hit;
  logic [3:0] near_fired;
  logic sum_set;
  logic sum_done;
  logic near_flag;
  logic indep_flag;
  logic err_flag;
  ahd_word_t rd_word;

  function automatic logic reg_ok(logic [7:0] a);
    reg_ok = (a[1:0] == 2'h0) && (a[7:4] <= 4'h4) && (a[7:4] != 4'h1 || a[3:2] == 2'h0);
  endfunction : reg_ok

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  assign AXI_AWREADY_OUT = !aw_ok && !AXI_BVALID_OUT;
  assign AXI_WREADY_OUT = !w_ok && !AXI_BVALID_OUT;
  assign AXI_ARREADY_OUT = !AXI_RVALID_OUT;
  assign wr_go = aw_ok && w_ok && !AXI_BVALID_OUT;

  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      aw_ok <= 1'b0;
      w_ok <= 1'b0;
      wr_addr <= 8'h00;
      wdata <= 32'h00000000;
      wstrb <= 4'h0;
      AXI_BVALID_OUT <= 1'b0;
      AXI_BRESP_OUT <= `AHD_RESP_OK;
    end else begin
      if (AXI_AWVALID_IN && AXI_AWREADY_OUT) begin
        aw_ok <= 1'b1;
        wr_addr <= AXI_AWADDR_IN;
      end
      if (AXI_WVALID_IN && AXI_WREADY_OUT) begin
        w_ok <= 1'b1;
        wdata <= AXI_WDATA_IN;
        wstrb <= AXI_WSTRB_IN;
      end
      if (wr_go) begin
        aw_ok <= 1'b0;
        w_ok <= 1'b0;
        AXI_BVALID_OUT <= 1'b1;
        AXI_BRESP_OUT <= reg_ok(wr_addr) ? `AHD_RESP_OK : `AHD_RESP_ERR;
      end else if (AXI_BREADY_IN) begin
        AXI_BVALID_OUT <= 1'b0;
      end
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      AXI_RVALID_OUT <= 1'b0;
      AXI_RDATA_OUT <= 32'h00000000;
      AXI_RRESP_OUT <= `AHD_RESP_OK;
    end else if (AXI_ARVALID_IN && AXI_ARREADY_OUT) begin
      AXI_RVALID_OUT <= 1'b1;
      AXI_RDATA_OUT <= rd_word;
      AXI_RRESP_OUT <= reg_ok(AXI_ARADDR_IN) ? `AHD_RESP_OK : `AHD_RESP_ERR;
    end else if (AXI_RREADY_IN) begin
      AXI_RVALID_OUT <= 1'b0;
    end
  end

  always_comb begin
    rd_word = 32'h00000000;
    case (AXI_ARADDR_IN[7:4])
      4'h0: begin
        case (AXI_ARADDR_IN[3:2])
          2'h0: rd_word = {20'h00000, ctrl};
          2'h2: rd_word = param;
          2'h3: rd_word = {24'h000000, busy, indep_flag, near_flag, err_flag, sum_done};
          default: rd_word = 32'h00000000;
        endcase
      end
      4'h1: rd_word = {28'h0000000, axis_done};
      4'h2: rd_word = {8'h00, vel[AXI_ARADDR_IN[3:2]]};
      4'h3: rd_word = {16'h0000, near[AXI_ARADDR_IN[3:2]]};
      4'h4: rd_word = pos[AXI_ARADDR_IN[3:2]];
      default: rd_word = 32'h00000000;
    endcase
  end

  // ****************************************
  // Registers and commands
  // ****************************************
  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      ctrl <= `AHD_CTRL_RST;
      param <= 32'h00000000;
      for (int i = 0; i < `AHD_AXES; i++) begin
        vel[i] <= `AHD_VEL_RST;
        near[i] <= `AHD_NEAR_RST;
      end
    end else if (wr_go && reg_ok(wr_addr)) begin
      if (wr_addr == `AHD_CTRL_OFS) ctrl <= 12'(ahd_strb({20'h00000, ctrl}, wdata, wstrb));
      if (wr_addr == `AHD_PARAM_OFS) param <= ahd_strb(param, wdata, wstrb);
      if (wr_addr[7:4] == `AHD_VEL_OFS >> 4) begin
        vel[wr_addr[3:2]] <= 24'(ahd_strb({8'h00, vel[wr_addr[3:2]]}, wdata, wstrb));
      end
      if (wr_addr[7:4] == `AHD_NEAR_OFS >> 4) begin
        near[wr_addr[3:2]] <= 16'(ahd_strb({16'h0000, near[wr_addr[3:2]]}, wdata, wstrb));
      end
    end
  end

  assign mode = ctrl[`AHD_CTRL_MODE];
  assign hold = ctrl[`AHD_CTRL_HOLD];
  assign near_en = ctrl[`AHD_CTRL_NEAREN];
  assign cmd_go = wr_go && wr_addr == `AHD_CMD_OFS && wstrb[0];
  assign op = ahd_op_e'(wdata[`AHD_CMD_OP]);
  assign ax = wdata[`AHD_CMD_AXIS];
  assign is_home = op inside {AHD_OP_HOME_FWD, AHD_OP_HOME_REV, AHD_OP_KILL_FWD, AHD_OP_KILL_REV};
  assign home_ok = cmd_go && is_home && !ahd_multi(mode) && !busy[ax];
  assign home_rej = cmd_go && is_home && !home_ok;
  assign start = home_ok ? (4'h1 << ax) : 4'h0;
  assign load = (wdata[`AHD_CMD_HASPAR] && wstrb[1]) ? param : 32'h00000000;
  assign flag_clear = cmd_go && op == AHD_OP_CLEAR;
  assign clr_done = flag_clear || START_MOVE_CLEAR_DONE_IN;

  for (genvar i = 0; i < `AHD_AXES; i++) begin : g_ax
    ahd_axis u_ax (
      .clk_in(REF_CLK_IN),
      .srst_in(SRST_IN),
      .start_in(start[i]),
      .dir_in(op == AHD_OP_HOME_REV || op == AHD_OP_KILL_REV),
      .kill_mode_in(op == AHD_OP_KILL_FWD || op == AHD_OP_KILL_REV),
      .load_in(load),
      .period_in(vel[i]),
      .home_in(HOME_IN[i]),
      .step_out(STEP_OUT[i]),
      .dir_out(DIR_OUT[i]),
      .busy_out(busy[i]),
      .pos_out(pos[i])
    );
  end

  // ****************************************
  // Done, nearly-done and interrupt flags
  // ****************************************
  always_comb begin
    de = DONE_IRQ_CMD_IN | (DEADBAND_DONE_CMD_IN & ~hold) | (pend_db & IN_DEADBAND_IN);
    de_g = (mode == 2'(AHD_MODE_ACTIVE)) ? (de & MOVE_AXES_IN) : de;
    ie = ctrl[`AHD_CTRL_INDEP] ? (MOVE_DONE_IN & MOVE_AXES_IN) : 4'h0;
    next_flags = axis_done | de_g | ie;
    for (int i = 0; i < `AHD_AXES; i++) begin
      near_hit[i] = DECEL_IN[i] && near_en[i] && !near_fired[i] &&
        REMAIN_IN[i*16 +: 16] <= near[i];
    end
    case (mode)
      2'(AHD_MODE_EVERY): sum_set = (|de_g) && (&next_flags);
      2'(AHD_MODE_ACTIVE): sum_set = (|de_g) && (next_flags & MOVE_AXES_IN) == MOVE_AXES_IN;
      default: sum_set = |de_g;
    endcase
  end

  // A flag set in the cycle of its clear survives
  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      axis_done <= 4'h0;
      sum_done <= 1'b0;
      pend_db <= 4'h0;
    end else begin
      axis_done <= (clr_done ? 4'h0 : axis_done) | de_g | ie;
      sum_done <= (clr_done ? 1'b0 : sum_done) | sum_set | (|ie);
      pend_db <= (clr_done ? 4'h0 : pend_db & ~de) | (DEADBAND_DONE_CMD_IN & hold);
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      near_fired <= 4'h0;
      near_flag <= 1'b0;
      indep_flag <= 1'b0;
      err_flag <= 1'b0;
      IRQ_OUT <= 1'b0;
    end else begin
      near_fired <= (near_fired & ~MOVE_DONE_IN) | near_hit;
      near_flag <= (flag_clear ? 1'b0 : near_flag) | (|near_hit);
      indep_flag <= (flag_clear ? 1'b0 : indep_flag) | (|ie);
      err_flag <= (flag_clear ? 1'b0 : err_flag) | home_rej;
      IRQ_OUT <= ctrl[`AHD_CTRL_IRQEN] && (sum_done || near_flag || indep_flag || err_flag);
    end
  end

  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (SRST_IN);

  a_home_reject: assert property (cmd_go && is_home && ahd_multi(mode) |->
    start == 4'h0 ##1 err_flag) else $error("home accepted in multi-axis mode");
  a_irq_gate: assert property (!ctrl[`AHD_CTRL_IRQEN] |=> !IRQ_OUT)
    else $error("interrupt raised while disabled");
  a_every_sum: assert property (mode == 2'(AHD_MODE_EVERY) && ie == 4'h0 &&
    !sum_done && !(&next_flags) |=> !sum_done) else $error("summary done set early");
  a_active_gate: assert property (mode == 2'(AHD_MODE_ACTIVE) && !MOVE_AXES_IN[0] &&
    !axis_done[0] |=> !axis_done[0]) else $error("inactive axis flagged done");
  a_indep_irq: assert property (ie != 4'h0 && ctrl[`AHD_CTRL_IRQEN]
    ##1 ctrl[`AHD_CTRL_IRQEN] |=> IRQ_OUT) else $error("independent interrupt missing");
  a_near_quiet: assert property (DECEL_IN == 4'h0 && !near_flag |=> !near_flag)
    else $error("nearly-done fired outside deceleration");
  a_near_start: assert property ($rose(DECEL_IN[0]) && near_en[0] && !near_fired[0] &&
    REMAIN_IN[15:0] <= near[0] |=> near_flag) else $error("nearly-done late");
  a_deadband_wait: assert property (pend_db[0] && !IN_DEADBAND_IN[0] &&
    !DONE_IRQ_CMD_IN[0] && !(DEADBAND_DONE_CMD_IN[0] && !hold[0]) && ie[0] == 1'b0 &&
    !axis_done[0] |=> !axis_done[0])
    else $error("deadband done before in position");
  a_hold_off: assert property (DEADBAND_DONE_CMD_IN[0] && !hold[0] &&
    mode == 2'(AHD_MODE_SINGLE) |=> axis_done[0] && sum_done)
    else $error("deadband done not plain with hold off");
  a_flag_clear: assert property (flag_clear && de_g == 4'h0 && ie == 4'h0 |=>
    axis_done == 4'h0 && !sum_done && !err_flag) else $error("flag clear incomplete");
  a_reset_quiet: assert property (disable iff (1'b0) SRST_IN |=>
    STEP_OUT == 4'h0 && !IRQ_OUT && axis_done == 4'h0 && !sum_done)
    else $error("reset left activity");
  c_every_done: cover property (mode == 2'(AHD_MODE_EVERY) && $rose(sum_done));
  c_near: cover property ($rose(near_flag));
  c_indep: cover property (ie != 4'h0 ##2 IRQ_OUT);
  c_reject: cover property (home_rej);
endmodule : ahd_top

// file: verification/ahd_switch_model.sv
// Home switch model that trips after a set number of step pulses
`timescale 1ns/1ps
module ahd_switch_model #(
  parameter int TRIP = 3
) (
  input wire logic clk_in,
  input wire logic arm_in,
  input wire logic [3:0] step_in,
  output logic [3:0] home_out
);
  logic [3:0] prev;
  int cnt [4];

  // ***************************************************
  // Switch closes once the axis has stepped TRIP times
  // ***************************************************
  always_ff @(posedge clk_in) begin
    prev <= step_in;
    for (int i = 0; i < 4; i++) begin
      if (!arm_in) begin
        cnt[i] <= 0;
        home_out[i] <= 1'b0;
      end else begin
        if (step_in[i] && !prev[i]) begin
          cnt[i] <= cnt[i] + 1;
        end
        home_out[i] <= (cnt[i] >= TRIP);
      end
    end
  end
endmodule : ahd_switch_model

// file: verification/tb_top.sv
// Self-checking bench for the axis homing and done block
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin failures++; \
  $display("unexpected at %0t: got %h expected %h", $time, (a), (e)); end end
module tb_top;
  import ahd_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  int failures = 0;
  int checked = 0;
  int cyc = 0;
  logic [7:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic arm = 1'b0, smcd = 1'b0;
  logic [31:0] wdata = '0, rd, rdata, p0;
  logic [3:0] done_cmd = '0, db_cmd = '0, in_db = '0, move_axes = '0, move_done = '0;
  logic [3:0] decel = '0, home, step, dir;
  logic [63:0] remain = '0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, resp;

  always #4 clk = ~clk;

  ahd_switch_model #(.TRIP(3)) sw (.clk_in(clk), .arm_in(arm), .step_in(step), .home_out(home));

  ahd_top dut (
    .REF_CLK_IN(clk), .SRST_IN(srst),
    .AXI_AWADDR_IN(awaddr), .AXI_AWVALID_IN(awvalid), .AXI_AWREADY_OUT(awready),
    .AXI_WDATA_IN(wdata), .AXI_WSTRB_IN(4'hf), .AXI_WVALID_IN(wvalid), .AXI_WREADY_OUT(wready),
    .AXI_BRESP_OUT(bresp), .AXI_BVALID_OUT(bvalid), .AXI_BREADY_IN(bready),
    .AXI_ARADDR_IN(araddr), .AXI_ARVALID_IN(arvalid), .AXI_ARREADY_OUT(arready),
    .AXI_RDATA_OUT(rdata), .AXI_RRESP_OUT(rresp), .AXI_RVALID_OUT(rvalid),
    .AXI_RREADY_IN(rready), .HOME_IN(home), .STEP_OUT(step), .DIR_OUT(dir),
    .DONE_IRQ_CMD_IN(done_cmd), .DEADBAND_DONE_CMD_IN(db_cmd), .IN_DEADBAND_IN(in_db),
    .MOVE_AXES_IN(move_axes), .MOVE_DONE_IN(move_done), .DECEL_IN(decel),
    .REMAIN_IN(remain), .START_MOVE_CLEAR_DONE_IN(smcd), .IRQ_OUT(irq)
  );

  // ***************************************************
  // Bus and pulse helpers
  // ***************************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (awready && awvalid) awvalid <= 1'b0;
      if (wready && wvalid) wvalid <= 1'b0;
      if (bvalid) begin
        resp = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask : wr

  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (arready && arvalid) arvalid <= 1'b0;
      if (rvalid) begin
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask : rd_reg

  task automatic chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd_reg(a);
    `CHK(rd & m, e)
  endtask : chk

  task automatic pls(input int k, input logic [3:0] m);
    @(posedge clk);
    case (k)
      0: done_cmd <= m;
      1: db_cmd <= m;
      default: move_done <= m;
    endcase
    @(posedge clk);
    done_cmd <= '0;
    db_cmd <= '0;
    move_done <= '0;
    repeat (3) @(posedge clk);
  endtask : pls

  task automatic clr;
    wr(8'h04, 32'h5);
    repeat (3) @(posedge clk);
  endtask : clr

  task automatic seek(input int ax, input logic [2:0] op, input logic hp);
    arm <= 1'b1;
    wr(8'h04, {23'h0, hp, 2'h0, 2'(ax), 1'b0, op});
    while (!home[ax]) @(posedge clk);
    `CHK(dir[ax], ~op[0])
  endtask : seek

  task automatic wait_idle;
    do rd_reg(8'h0c); while ((rd & 32'hf0) != '0);
    arm <= 1'b0;
    @(posedge clk);
  endtask : wait_idle

  // ***************************************************
  // Scenarios
  // ***************************************************
  task automatic t_reset;
    `CHK(irq, 1'b0)
    `CHK(step, 4'h0)
    chk(8'h0c, 32'hffffffff, 32'h0);
    chk(8'h10, 32'hf, 32'h0);
    chk(8'h20, 32'hffffff, 32'h1e848);
    rd_reg(8'h7c);
    `CHK(resp, 2'b10)
    wr(8'h7c, 32'h0);
    `CHK(resp, 2'b10)
  endtask : t_reset

  task automatic t_homes;
    wr(8'h08, 32'h1234);
    seek(0, 3'h1, 1'b1);
    chk(8'h40, 32'hffffffff, 32'h1234);
    chk(8'h0c, 32'h10, 32'h10);
    wait_idle;
    seek(1, 3'h2, 1'b0);
    chk(8'h44, 32'hffffffff, 32'h0);
    chk(8'h0c, 32'h20, 32'h20);
    wait_idle;
    seek(2, 3'h3, 1'b1);
    repeat (2) @(posedge clk);
    `CHK(step[2], 1'b0)
    chk(8'h0c, 32'h40, 32'h0);
    chk(8'h48, 32'hffffffff, 32'h3);
    wait_idle;
    seek(3, 3'h4, 1'b0);
    repeat (2) @(posedge clk);
    `CHK(step[3], 1'b0)
    chk(8'h0c, 32'h80, 32'h0);
    chk(8'h4c, 32'hffffffff, 32'hfffffffd);
    wait_idle;
  endtask : t_homes

  task automatic t_reject;
    rd_reg(8'h40);
    p0 = rd;
    wr(8'h00, 32'h1);
    arm <= 1'b1;
    wr(8'h04, 32'h101);
    repeat (800) @(posedge clk);
    `CHK(home[0], 1'b0)
    chk(8'h40, 32'hffffffff, p0);
    chk(8'h0c, 32'h12, 32'h2);
    clr;
    chk(8'h0c, 32'hf, 32'h0);
    arm <= 1'b0;
  endtask : t_reject

  task automatic t_done;
    wr(8'h00, 32'h8);
    pls(0, 4'h4);
    chk(8'h10, 32'hf, 32'h4);
    `CHK(irq, 1'b1)
    clr;
    chk(8'h10, 32'hf, 32'h0);
    `CHK(irq, 1'b0)
    wr(8'h00, 32'h0);
    pls(0, 4'h4);
    chk(8'h10, 32'hf, 32'h4);
    `CHK(irq, 1'b0)
    clr;
  endtask : t_done

  task automatic t_modes;
    wr(8'h00, 32'h9);
    pls(0, 4'h7);
    chk(8'h10, 32'hf, 32'h7);
    chk(8'h0c, 32'h1, 32'h0);
    pls(0, 4'h8);
    chk(8'h0c, 32'h1, 32'h1);
    smcd <= 1'b1;
    @(posedge clk);
    smcd <= 1'b0;
    repeat (2) @(posedge clk);
    chk(8'h10, 32'hf, 32'h0);
    clr;
    wr(8'h00, 32'ha);
    move_axes <= 4'h6;
    pls(0, 4'hf);
    chk(8'h10, 32'hf, 32'h6);
    clr;
  endtask : t_modes

  task automatic t_near;
    wr(8'h30, 32'ha);
    wr(8'h00, 32'h100);
    remain <= 64'h5;
    repeat (3) @(posedge clk);
    chk(8'h0c, 32'h4, 32'h0);
    decel <= 4'h1;
    remain <= 64'h14;
    repeat (3) @(posedge clk);
    chk(8'h0c, 32'h4, 32'h0);
    remain <= 64'ha;
    repeat (3) @(posedge clk);
    chk(8'h0c, 32'h4, 32'h4);
    decel <= 4'h0;
    remain <= 64'h5;
    pls(2, 4'h1);
    clr;
    decel <= 4'h1;
    repeat (3) @(posedge clk);
    chk(8'h0c, 32'h4, 32'h4);
    decel <= 4'h0;
    clr;
  endtask : t_near

  task automatic t_dead;
    wr(8'h00, 32'h18);
    pls(1, 4'h1);
    chk(8'h10, 32'hf, 32'h0);
    in_db <= 4'h1;
    repeat (3) @(posedge clk);
    chk(8'h10, 32'hf, 32'h1);
    `CHK(irq, 1'b1)
    in_db <= 4'h0;
    clr;
    wr(8'h00, 32'h8);
    pls(1, 4'h1);
    chk(8'h10, 32'hf, 32'h1);
    clr;
  endtask : t_dead

  task automatic t_indep;
    wr(8'h00, 32'hc);
    move_axes <= 4'h2;
    pls(2, 4'h1);
    chk(8'h0c, 32'h8, 32'h0);
    `CHK(irq, 1'b0)
    pls(2, 4'h2);
    chk(8'h0c, 32'h8, 32'h8);
    `CHK(irq, 1'b1)
    clr;
  endtask : t_indep

  task automatic t_rst2;
    wr(8'h00, 32'h8);
    pls(0, 4'h1);
    wr(8'h04, 32'h11);
    repeat (4) @(posedge clk);
    `CHK(irq, 1'b1)
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    `CHK(step, 4'h0)
    `CHK(irq, 1'b0)
    chk(8'h0c, 32'hff, 32'h0);
    chk(8'h10, 32'hf, 32'h0);
  endtask : t_rst2

  task automatic finish_test;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test

  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      failures++;
      finish_test;
    end
  end

  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    t_reset;
    // Fast homing rate keeps the run short; load accuracy is not modelled
    for (int i = 0; i < 4; i++) wr(8'(32 + 4 * i), 32'hfa);
    t_homes;
    t_reject;
    t_done;
    t_modes;
    t_near;
    t_dead;
    t_indep;
    t_rst2;
    finish_test;
  end
endmodule : tb_top
